// File: hw/acs_pkg.sv
// Constants shared by the conversion scheduler: register map, fields, timing tables
package acs_pkg;

    // ==========================================================
    // Register map
    localparam logic [5:0] ADDR_CONFIG = 6'h00;
    localparam logic [5:0] ADDR_ADC_SETTINGS = 6'h01;
    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    localparam logic [15:0] ADC_SETTINGS_RESET = 16'hFB68;

    // ==========================================================
    // Field positions
    localparam int MODE_LSB = 12;
    localparam int BUS_CT_LSB = 9;
    localparam int SHUNT_CT_LSB = 6;
    localparam int TEMP_CT_LSB = 3;
    localparam int AVG_LSB = 0;
    localparam int CFG_SRST_BIT = 15;
    localparam int CFG_DELAY_LSB = 6;
    localparam int CFG_RANGE_BIT = 4;

    // ==========================================================
    // Timing
    localparam int unsigned CLOCK_PERIOD_PS = 25000;
    localparam int unsigned US_IN_PS = 1000000;
    localparam int unsigned US_TICK_CYCLES = US_IN_PS / CLOCK_PERIOD_PS;
    localparam int unsigned DELAY_STEP_MS = 2;
    localparam int unsigned DELAY_STEP_US = DELAY_STEP_MS * 1000;

    // Conversion time in microseconds, indexed by the 3-bit time code
    localparam logic [12:0] CONV_TIME_US [8] = '{
        13'h0032, 13'h0054, 13'h0096, 13'h0118,
        13'h021C, 13'h041C, 13'h081A, 13'h1018
    };

    // Samples averaged per result, indexed by the 3-bit averaging code
    localparam logic [10:0] AVG_SAMPLES [8] = '{
        11'h001, 11'h004, 11'h010, 11'h040,
        11'h080, 11'h100, 11'h200, 11'h400
    };

    // ==========================================================
    // Scheduler states and channel numbers
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_CONV = 2'b10
    } acs_state_type;

    localparam logic [1:0] CHAN_BUS = 2'h0;
    localparam logic [1:0] CHAN_SHUNT = 2'h1;
    localparam logic [1:0] CHAN_TEMP = 2'h2;

endpackage

// File: hw/acs_scheduler.sv
// Conversion scheduler: settings registers and the channel/averaging sequencer
`timescale 1ns/1ps

// How it works
// - Mode field bits 15-12, reset Fh; codes 0h and 8h shut conversions down.
// - Codes 1h-7h run one pass over the channels picked by the low bits.
// - Codes 9h-Fh convert the picked channels over and over without stopping.
// - Bus time field bits 11-9, reset 5h, picks 50 to 4120 us.
// - Shunt time field bits 8-6, reset 5h, same eight-step time encoding.
// - Temperature time field bits 5-3, reset 5h, same eight-step time encoding.
// - Averaging field bits 2-0, reset 0h, picks 1 to 1024 samples per result.
// - The averaging count applies to every enabled channel.
// - Results update only once the whole averaging run has finished.
// - First conversion after start-up waits the programmed delay in 2 ms steps.
// - Writing the reset bit restores all registers to defaults; the bit self-clears.
module acs_scheduler #(
    parameter int unsigned US_TICK_CYCLES = acs_pkg::US_TICK_CYCLES,
    parameter int unsigned DELAY_STEP_US = acs_pkg::DELAY_STEP_US
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // Register port
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [5:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    // Converter control
    output logic conv_start_out,
    output logic [1:0] conv_channel_out,
    output logic conv_busy_out,
    output logic sample_done_out,
    output logic [2:0] result_update_out,
    output logic adc_range_out
);

    // ==========================================================
    // Registers
    logic [15:0] settings_reg;
    logic [7:0] delay_code_reg;
    logic range_reg;
    logic soft_rst;
    logic sys_rst;
    logic wr_settings;

    assign soft_rst = reg_wr_in && (reg_addr_in == acs_pkg::ADDR_CONFIG)
                      && reg_wdata_in[acs_pkg::CFG_SRST_BIT];
    assign sys_rst = srst_in | soft_rst;
    assign wr_settings = reg_wr_in && !soft_rst && (reg_addr_in == acs_pkg::ADDR_ADC_SETTINGS);

    // Reset bit is never stored, so it reads back as zero
    always_ff @(posedge clock_in) begin
        if (sys_rst) begin
            settings_reg <= acs_pkg::ADC_SETTINGS_RESET;
        end else if (wr_settings) begin
            settings_reg <= reg_wdata_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst) begin
            delay_code_reg <= acs_pkg::CONFIG_RESET[acs_pkg::CFG_DELAY_LSB +: 8];
            range_reg <= acs_pkg::CONFIG_RESET[acs_pkg::CFG_RANGE_BIT];
        end else if (reg_wr_in && reg_addr_in == acs_pkg::ADDR_CONFIG) begin
            delay_code_reg <= reg_wdata_in[acs_pkg::CFG_DELAY_LSB +: 8];
            range_reg <= reg_wdata_in[acs_pkg::CFG_RANGE_BIT];
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                acs_pkg::ADDR_CONFIG: begin
                    reg_rdata_out <= {2'h0, delay_code_reg, 1'b0, range_reg, 4'h0};
                end
                acs_pkg::ADDR_ADC_SETTINGS: begin
                    reg_rdata_out <= settings_reg;
                end
                default: begin
                    reg_rdata_out <= 16'h0000;
                end
            endcase
        end
    end

    assign adc_range_out = range_reg;

    // ==========================================================
    // Decoded settings
    logic [3:0] mode;
    logic [2:0] chan_en;
    logic continuous;
    logic [10:0] avg_samples;

    assign mode = settings_reg[acs_pkg::MODE_LSB +: 4];
    // Low three mode bits are the bus/shunt/temperature enables; bit 3 picks repeat
    assign chan_en = mode[2:0];
    assign continuous = mode[3];
    assign avg_samples = acs_pkg::AVG_SAMPLES[settings_reg[acs_pkg::AVG_LSB +: 3]];

    // ==========================================================
    // Sequencer
    acs_pkg::acs_state_type state_reg;
    acs_pkg::acs_state_type state_next;
    logic [1:0] chan_reg;
    logic [19:0] time_cnt_reg;
    logic [15:0] div_cnt_reg;
    logic [10:0] round_reg;
    logic trig_pending_reg;
    logic first_done_reg;
    logic us_tick;
    logic launch;
    logic done_sample;
    logic wrap;
    logic last_round;
    logic run_ok;
    logic [1:0] first_chan;
    logic [1:0] next_chan;
    logic [1:0] launch_chan;
    logic [2:0] ct_code;
    logic [19:0] conv_target;
    logic [19:0] delay_target;

    assign us_tick = (div_cnt_reg == 16'(US_TICK_CYCLES - 1));
    assign run_ok = (chan_en != 3'h0) && (continuous || trig_pending_reg);
    assign last_round = (round_reg == avg_samples - 11'h001);
    assign delay_target = 20'(32'(delay_code_reg) * DELAY_STEP_US);

    always_comb begin
        case (chan_reg)
            acs_pkg::CHAN_BUS: ct_code = settings_reg[acs_pkg::BUS_CT_LSB +: 3];
            acs_pkg::CHAN_SHUNT: ct_code = settings_reg[acs_pkg::SHUNT_CT_LSB +: 3];
            default: ct_code = settings_reg[acs_pkg::TEMP_CT_LSB +: 3];
        endcase
    end

    assign conv_target = {7'h00, acs_pkg::CONV_TIME_US[ct_code]};

    // Channel order within a pass is bus, shunt, temperature
    always_comb begin
        first_chan = chan_en[0] ? acs_pkg::CHAN_BUS
                   : (chan_en[1] ? acs_pkg::CHAN_SHUNT : acs_pkg::CHAN_TEMP);
        next_chan = first_chan;
        wrap = 1'b1;
        if (chan_reg == acs_pkg::CHAN_BUS && chan_en[1]) begin
            next_chan = acs_pkg::CHAN_SHUNT;
            wrap = 1'b0;
        end else if (chan_reg != acs_pkg::CHAN_TEMP && chan_en[2]) begin
            next_chan = acs_pkg::CHAN_TEMP;
            wrap = 1'b0;
        end
    end

    assign launch_chan = (state_reg == acs_pkg::ST_CONV) ? next_chan : first_chan;

    always_comb begin
        state_next = state_reg;
        launch = 1'b0;
        done_sample = 1'b0;
        case (state_reg)
            acs_pkg::ST_IDLE: begin
                if (run_ok) begin
                    if (!first_done_reg && delay_target != 20'h00000) begin
                        state_next = acs_pkg::ST_DELAY;
                    end else begin
                        state_next = acs_pkg::ST_CONV;
                        launch = 1'b1;
                    end
                end
            end
            acs_pkg::ST_DELAY: begin
                if (us_tick && time_cnt_reg == delay_target - 20'h00001) begin
                    state_next = acs_pkg::ST_CONV;
                    launch = 1'b1;
                end
            end
            acs_pkg::ST_CONV: begin
                if (us_tick && time_cnt_reg == conv_target - 20'h00001) begin
                    done_sample = 1'b1;
                    // Single shot stops after the last averaging round of one pass
                    if (!wrap || !last_round || continuous) begin
                        launch = 1'b1;
                    end else begin
                        state_next = acs_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                state_next = acs_pkg::ST_IDLE;
            end
        endcase
        // A settings write aborts the pass so no result mixes two setups
        if (wr_settings) begin
            state_next = acs_pkg::ST_IDLE;
            launch = 1'b0;
            done_sample = 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst) begin
            state_reg <= acs_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Divider restarts with each phase so every duration is exact in cycles
    always_ff @(posedge clock_in) begin
        if (sys_rst || launch || state_next != state_reg || us_tick) begin
            div_cnt_reg <= 16'h0000;
        end else begin
            div_cnt_reg <= div_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst || launch || state_next != state_reg) begin
            time_cnt_reg <= 20'h00000;
        end else if (us_tick) begin
            time_cnt_reg <= time_cnt_reg + 20'h00001;
        end
    end

    // Averaging round counter shared by all enabled channels
    always_ff @(posedge clock_in) begin
        if (sys_rst || state_reg != acs_pkg::ST_CONV || wr_settings) begin
            round_reg <= 11'h000;
        end else if (done_sample && wrap) begin
            round_reg <= last_round ? 11'h000 : round_reg + 11'h001;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst) begin
            trig_pending_reg <= 1'b0;
        end else if (wr_settings) begin
            trig_pending_reg <= !reg_wdata_in[acs_pkg::MODE_LSB + 3]
                                && (reg_wdata_in[acs_pkg::MODE_LSB +: 3] != 3'h0);
        end else if (state_reg == acs_pkg::ST_IDLE && state_next != acs_pkg::ST_IDLE) begin
            trig_pending_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst) begin
            first_done_reg <= 1'b0;
        end else if (launch) begin
            first_done_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst) begin
            chan_reg <= acs_pkg::CHAN_BUS;
        end else if (launch) begin
            chan_reg <= launch_chan;
        end
    end

    // ==========================================================
    // Converter outputs
    always_ff @(posedge clock_in) begin
        if (sys_rst) begin
            conv_start_out <= 1'b0;
            sample_done_out <= 1'b0;
            result_update_out <= 3'h0;
        end else begin
            conv_start_out <= launch;
            sample_done_out <= done_sample;
            // All enabled results update together after the final round
            result_update_out <= (done_sample && wrap && last_round)
                                 ? chan_en : 3'h0;
        end
    end

    assign conv_channel_out = chan_reg;
    assign conv_busy_out = (state_reg == acs_pkg::ST_CONV);

endmodule // acs_scheduler

// File: testbench/acs_scheduler_chk.sv
// Port checker for the conversion scheduler
`timescale 1ns/1ps
module acs_scheduler_chk #(
    parameter int unsigned US_TICK_CYCLES = 1
) (
    // Clock, reset and register port
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [5:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic [15:0] reg_rdata_out,
    // Converter control
    input wire logic conv_start_out,
    input wire logic [1:0] conv_channel_out,
    input wire logic conv_busy_out,
    input wire logic sample_done_out,
    input wire logic [2:0] result_update_out
);
    // ==========================================================
    // Shadow of the settings and sample counters
    logic [15:0] set_reg;
    int cnt_reg;
    int exp_reg;
    int done_reg;
    wire rst_w = srst_in || (reg_wr_in && reg_addr_in == 6'h00 && reg_wdata_in[15]);
    wire set_w = reg_wr_in && reg_addr_in == 6'h01;
    wire [2:0] mask = set_reg[14:12];
    always_ff @(posedge clock_in)
        if (rst_w) set_reg <= 16'hFB68;
        else if (set_w) set_reg <= reg_wdata_in;
    always_ff @(posedge clock_in) begin
        cnt_reg <= conv_start_out ? 1 : cnt_reg + 1;
        if (conv_start_out)
            exp_reg <= acs_pkg::CONV_TIME_US[set_reg[11-3*conv_channel_out -: 3]] * US_TICK_CYCLES;
    end
    // A settings write aborts the pass, so the sample count starts over
    always_ff @(posedge clock_in)
        if (rst_w || set_w || result_update_out != 3'h0) done_reg <= 0;
        else if (sample_done_out) done_reg <= done_reg + 1;

    // ==========================================================
    // Properties
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);
    a_done_time: assert property (sample_done_out |-> cnt_reg == exp_reg)
        else $error("sample finished at the wrong time");
    a_update_pair: assert property (result_update_out != 3'h0 |-> sample_done_out)
        else $error("update without a finished sample");
    a_avg_count: assert property (result_update_out != 3'h0 |-> done_reg + 1 ==
        acs_pkg::AVG_SAMPLES[set_reg[2:0]] * $countones(mask))
        else $error("update after wrong number of samples");
    a_update_mask: assert property (result_update_out != 3'h0 |->
        result_update_out == mask)
        else $error("update mask differs from enabled channels");
    a_chan_enabled: assert property (conv_start_out |-> mask[conv_channel_out])
        else $error("conversion of a disabled channel");
    a_shut_idle: assert property (mask == 3'h0 |-> !conv_start_out)
        else $error("conversion started in shutdown");
    a_single_stop: assert property (result_update_out != 3'h0 && !set_reg[15] |=>
        !conv_busy_out)
        else $error("converter still busy after single pass");
    a_cont_next: assert property (result_update_out != 3'h0 && set_reg[15] |->
        conv_start_out)
        else $error("continuous mode did not restart");
    a_read_data: assert property (reg_rd_in && !reg_wr_in && reg_addr_in == 6'h01 |=>
        reg_rdata_out == $past(set_reg))
        else $error("settings read back wrong");
    a_chan_hold: assert property ($changed(conv_channel_out) |->
        conv_start_out || $past(rst_w))
        else $error("channel changed without a start");
    cover property (result_update_out != 3'h0 && set_reg[2:0] != 3'h0);
    cover property (result_update_out == 3'h7 && !set_reg[15]);
    cover property (conv_start_out && conv_channel_out == 2'h2);
endmodule // acs_scheduler_chk

// File: testbench/tb_top.sv
// Self-checking bench for the conversion scheduler
`timescale 1ns/1ps
module tb_top;
    logic clock_in = 1'b0;
    logic srst_in = 1'b1;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [5:0] reg_addr_in = 6'h00;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic [15:0] reg_rdata_out;
    logic conv_start_out, conv_busy_out, sample_done_out, adc_range_out;
    logic [1:0] conv_channel_out;
    logic [2:0] result_update_out;
    int err_total = 0;
    int check_count = 0;
    int cycle_count = 0;
    int wait_n = 0;
    int seed = 32'h93A6;
    int avg_tab[8] = '{1, 4, 16, 64, 128, 256, 512, 1024};

    // Short counts keep every pass within a few thousand cycles
    acs_scheduler #(.US_TICK_CYCLES(1), .DELAY_STEP_US(2)) dut (
        .clock_in(clock_in), .srst_in(srst_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .conv_start_out(conv_start_out), .conv_channel_out(conv_channel_out),
        .conv_busy_out(conv_busy_out), .sample_done_out(sample_done_out),
        .result_update_out(result_update_out), .adc_range_out(adc_range_out));

    initial forever #12.5 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 60000) begin
            err_total++;
            wrap_up();
        end
    end

    // ==========================================================
    // Helpers
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(negedge clock_in);
        reg_wr_in = 1'b1;
        reg_addr_in = a;
        reg_wdata_in = d;
        @(negedge clock_in);
        reg_wr_in = 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] exp);
        @(negedge clock_in);
        reg_rd_in = 1'b1;
        reg_addr_in = a;
        @(negedge clock_in);
        reg_rd_in = 1'b0;
        chk("read data", exp, reg_rdata_out);
    endtask
    function automatic logic [1:0] nxt(input logic [2:0] m, input logic [1:0] p);
        logic [1:0] c;
        c = p;
        repeat (3) begin
            c = (c == 2'h2) ? 2'h0 : c + 2'h1;
            if (m[c]) return c;
        end
        return c;
    endfunction
    function automatic logic [15:0] exp_dones(input logic [15:0] s);
        return 16'(avg_tab[s[2:0]] * $countones(s[14:12]));
    endfunction
    // One pass: follow channel order, count samples, then check what follows it
    task automatic run(input logic [15:0] s);
        int dones;
        logic [1:0] last;
        logic live;
        dones = 0;
        last = 2'h3;
        live = s[15] && s[14:12] != 3'h0;
        wr(6'h01, s);
        repeat (s[14:12] == 3'h0 ? 200 : 9000) begin
            @(posedge clock_in);
            #1;
            if (sample_done_out === 1'b1) dones++;
            if (result_update_out !== 3'h0) break;
            if (conv_start_out === 1'b1) begin
                last = nxt(s[14:12], last);
                chk("channel", {14'h0, last}, {14'h0, conv_channel_out});
            end
        end
        chk("update mask", {13'h0, s[14:12]}, {13'h0, result_update_out});
        chk("samples", exp_dones(s), 16'(dones));
        chk("restart", {15'h0, live}, {15'h0, conv_start_out});
        repeat (30) @(posedge clock_in);
        #1;
        chk("busy", {15'h0, live}, {15'h0, conv_busy_out});
    endtask
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clock_in);
        @(negedge clock_in);
        srst_in = 1'b0;
        rd(6'h01, 16'hFB68);
        rd(6'h00, 16'h0000);
        rd(6'h2A, 16'h0000);
        run(16'hFB68);
        run(16'h7012);
        for (int m = 0; m < 16; m++) begin
            run((16'(m) << 12) | (16'($random(seed)) & 16'h0249));
        end
        wr(6'h00, 16'h7FFF);
        rd(6'h00, 16'h3FD0);
        chk("range", 16'h0001, {15'h0, adc_range_out});
        wr(6'h00, 16'h8000);
        rd(6'h01, 16'hFB68);
        rd(6'h00, 16'h0000);
        chk("range", 16'h0000, {15'h0, adc_range_out});
        // Second reset mid-run; a shutdown write on the first edge after it keeps the delay armed
        @(negedge clock_in);
        srst_in = 1'b1;
        repeat (3) @(negedge clock_in);
        srst_in = 1'b0;
        reg_wr_in = 1'b1;
        reg_addr_in = 6'h01;
        reg_wdata_in = 16'h0000;
        @(negedge clock_in);
        reg_wr_in = 1'b0;
        wr(6'h00, 16'h0400);
        // Code 10h is 16 steps of two cycles, plus the launch edge; later starts skip it
        for (int k = 0; k < 2; k++) begin
            wr(6'h01, 16'h1000);
            wait_n = 0;
            while (conv_start_out !== 1'b1 && wait_n < 200) begin
                @(posedge clock_in);
                #1;
                wait_n++;
            end
            chk("start delay", (k == 0) ? 16'h0021 : 16'h0001, 16'(wait_n));
        end
        wrap_up();
    end
endmodule // tb_top

bind acs_scheduler acs_scheduler_chk #(.US_TICK_CYCLES(US_TICK_CYCLES)) u_chk (
    .clock_in(clock_in), .srst_in(srst_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .conv_start_out(conv_start_out), .conv_channel_out(conv_channel_out),
    .conv_busy_out(conv_busy_out), .sample_done_out(sample_done_out),
    .result_update_out(result_update_out));
